// ===== core/eth_host_irq_rx_regs.sv
// Host interrupt mask, byte-order probe, FIFO thresholds and receive configuration
`timescale 1ns/1ps
`default_nettype none

module eth_host_irq_rx_regs (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire eth_host_regs_pkg::host_req_t host_req_in,
  input wire logic [31:0] irq_source_status_in,
  input wire eth_host_regs_pkg::fifo_levels_t fifo_levels_in,
  input wire eth_host_regs_pkg::rx_read_t rx_read_in,
  output logic [31:0] host_rdata_out,
  output logic host_irq_out,
  output logic tx_space_avail_irq_out,
  output logic tx_stat_level_irq_out,
  output logic rx_stat_level_irq_out,
  output logic rx_dma_irq_out,
  output logic rx_flush_out,
  output logic rx_pad_out,
  output logic [1:0] rx_byte_offset_out,
  output logic [2:0] rx_dword_offset_out
);

  eth_host_regs_pkg::bank_state_t st;
  eth_host_regs_pkg::bank_state_t next_st;

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  logic wr_en;
  logic rd_en;
  logic wr_mask;
  logic wr_thresh;
  logic wr_rx;
  logic counted_read;
  logic pad_read;
  logic [2:0] pos_after;
  logic [2:0] align_mask;
  logic [31:0] read_word;

  assign wr_en = host_req_in.sel & host_req_in.wr;
  assign rd_en = host_req_in.sel & host_req_in.rd;
  assign wr_mask = wr_en &
    (host_req_in.addr == eth_host_regs_pkg::IRQ_SOURCE_MASK_OFFSET);
  assign wr_thresh = wr_en &
    (host_req_in.addr == eth_host_regs_pkg::FIFO_LEVEL_THRESHOLDS_OFFSET);
  assign wr_rx = wr_en &
    (host_req_in.addr == eth_host_regs_pkg::RECEIVE_CONFIG_OFFSET);

  // Padding reads carry no packet data, so they neither count nor advance
  assign pad_read = rx_read_in.dword_read & (st.pad_left != 3'h0);
  assign counted_read = rx_read_in.dword_read & ~pad_read;
  assign pos_after = st.buf_pos + 3'h1;

  // ----------------------------------------
  // End alignment modulus
  // ----------------------------------------
  always_comb begin
    unique case (eth_host_regs_pkg::end_align_t'(st.end_align))
      eth_host_regs_pkg::ALIGN_4_BYTE: begin
        align_mask = eth_host_regs_pkg::ALIGN_4_DWORD_MASK;
      end
      eth_host_regs_pkg::ALIGN_16_BYTE: begin
        align_mask = eth_host_regs_pkg::ALIGN_16_DWORD_MASK;
      end
      eth_host_regs_pkg::ALIGN_32_BYTE: begin
        align_mask = eth_host_regs_pkg::ALIGN_32_DWORD_MASK;
      end
      eth_host_regs_pkg::ALIGN_RESERVED: begin
        // Reserved code behaves as plain dword alignment
        align_mask = eth_host_regs_pkg::ALIGN_4_DWORD_MASK;
      end
    endcase
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb begin
    read_word = 32'h0000_0000;
    unique case (host_req_in.addr)
      eth_host_regs_pkg::IRQ_SOURCE_MASK_OFFSET: begin
        read_word = st.irq_source_mask;
      end
      eth_host_regs_pkg::BYTE_ORDER_PROBE_OFFSET: begin
        read_word = eth_host_regs_pkg::BYTE_ORDER_PROBE_VALUE;
      end
      eth_host_regs_pkg::FIFO_LEVEL_THRESHOLDS_OFFSET: begin
        read_word[eth_host_regs_pkg::TX_AVAIL_LIMIT_LSB +: 8] = st.tx_avail_limit;
        read_word[eth_host_regs_pkg::TX_STAT_LIMIT_LSB +: 8] = st.tx_stat_limit;
        read_word[eth_host_regs_pkg::RX_STAT_LIMIT_LSB +: 8] = st.rx_stat_limit;
      end
      eth_host_regs_pkg::RECEIVE_CONFIG_OFFSET: begin
        read_word[eth_host_regs_pkg::END_ALIGN_LSB +: 2] = st.end_align;
        read_word[eth_host_regs_pkg::DWORD_COUNTDOWN_LSB +: 12] =
          st.rx_dword_countdown;
        read_word[eth_host_regs_pkg::RX_FLUSH_BIT] = st.rx_flush;
        read_word[eth_host_regs_pkg::START_OFFSET_LSB +: 5] = st.rx_start_offset;
      end
      default: begin
        // Unmapped offsets and reserved bits read as zero
        read_word = 32'h0000_0000;
      end
    endcase
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    next_st = st;

    // Mask register; reserved bits never store
    if (wr_mask) begin
      next_st.irq_source_mask =
        host_req_in.wdata & eth_host_regs_pkg::IRQ_SOURCE_MASK_RW;
    end

    // Threshold register
    if (wr_thresh) begin
      next_st.tx_avail_limit =
        host_req_in.wdata[eth_host_regs_pkg::TX_AVAIL_LIMIT_LSB +: 8];
      next_st.tx_stat_limit =
        host_req_in.wdata[eth_host_regs_pkg::TX_STAT_LIMIT_LSB +: 8];
      next_st.rx_stat_limit =
        host_req_in.wdata[eth_host_regs_pkg::RX_STAT_LIMIT_LSB +: 8];
    end

    // Receive configuration fields
    if (wr_rx) begin
      next_st.end_align = host_req_in.wdata[eth_host_regs_pkg::END_ALIGN_LSB +: 2];
      next_st.rx_start_offset =
        host_req_in.wdata[eth_host_regs_pkg::START_OFFSET_LSB +: 5];
    end

    // Flush is a one-cycle pulse that clears itself
    next_st.rx_flush = wr_rx & host_req_in.wdata[eth_host_regs_pkg::RX_FLUSH_BIT];

    // Dword countdown: a host write wins over a same-cycle decrement
    next_st.rx_dma_irq = 1'b0;
    if (wr_rx) begin
      next_st.rx_dword_countdown =
        host_req_in.wdata[eth_host_regs_pkg::DWORD_COUNTDOWN_LSB +: 12];
    end else if (counted_read && (st.rx_dword_countdown != 12'h000)) begin
      next_st.rx_dword_countdown = st.rx_dword_countdown - 12'h001;
      // Irq fires once, on the read that reaches zero
      next_st.rx_dma_irq = (st.rx_dword_countdown == 12'h001);
    end

    // Dword part of the offset is picked up on the next dword read
    if (rx_read_in.dword_read) begin
      next_st.dword_offset_applied = st.rx_start_offset[4:2];
    end

    // End-of-buffer padding
    if (counted_read) begin
      if (rx_read_in.last_dword) begin
        // Dwords still missing to reach the next alignment boundary
        next_st.pad_left = (3'h0 - pos_after) & align_mask;
        next_st.buf_pos = 3'h0;
      end else begin
        next_st.buf_pos = pos_after;
      end
    end else if (pad_read) begin
      next_st.pad_left = st.pad_left - 3'h1;
    end

    // A flush discards the buffer being read, padding included
    if (next_st.rx_flush) begin
      next_st.buf_pos = 3'h0;
      next_st.pad_left = 3'h0;
    end
    next_st.rx_pad = (next_st.pad_left != 3'h0);

    // Status is never altered here; only the output is gated
    next_st.host_irq = |(irq_source_status_in & st.irq_source_mask);

    // Read data lands one cycle after the strobe and then holds
    if (rd_en) begin
      next_st.rdata = read_word;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st <= eth_host_regs_pkg::BANK_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // FIFO level events
  // ----------------------------------------
  level_above_cmp u_tx_space_cmp (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .level_in(fifo_levels_in.tx_free_blocks),
    .limit_in(st.tx_avail_limit),
    .above_out(tx_space_avail_irq_out)
  );

  level_above_cmp u_tx_stat_cmp (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .level_in(fifo_levels_in.tx_stat_used),
    .limit_in(st.tx_stat_limit),
    .above_out(tx_stat_level_irq_out)
  );

  level_above_cmp u_rx_stat_cmp (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .level_in(fifo_levels_in.rx_stat_used),
    .limit_in(st.rx_stat_limit),
    .above_out(rx_stat_level_irq_out)
  );

  // ----------------------------------------
  // Outputs, all straight from state flops
  // ----------------------------------------
  assign host_rdata_out = st.rdata;
  assign host_irq_out = st.host_irq;
  assign rx_dma_irq_out = st.rx_dma_irq;
  assign rx_flush_out = st.rx_flush;
  assign rx_pad_out = st.rx_pad;
  // Byte part is trusted static while receiving
  assign rx_byte_offset_out = st.rx_start_offset[1:0];
  assign rx_dword_offset_out = st.dword_offset_applied;

endmodule

`default_nettype wire

// ===== include/eth_host_regs_pkg.sv
// Constants and carriers for the host interrupt-mask / receive-configuration register group
//
// Summary of operation
// - A set mask bit lets its status source drive the host interrupt output.
// - Status bits track their sources regardless of mask; masking gates output only.
// - Mask bits 31, 25, 24, 23 are read/write enables, reset to zero.
// - Mask bits 21 down to 16 are read/write enables, reset to zero.
// - Mask bits 15-13, 10-6, 4-3 and 2-0 are read/write enables, reset zero.
// - Byte-order probe is read-only and always returns 87654321h.
// - TX space limit, bits 31-24, in 64-byte blocks, default 48h; irq when exceeded.
// - TX status limit, bits 23-16, in dwords, default 00h; irq when exceeded.
// - RX status limit, bits 7-0, in dwords; irq when occupancy exceeds it.
// - End alignment bits 31:30: 00 4-byte, 01 16-byte, 10 32-byte, 11 reserved.
// - Device pads last buffer transfer up to alignment; host discards the padding.
// - 12-bit countdown at 27-16 gives dwords read before receive-DMA irq.
// - Countdown decrements per dword read; host may overwrite it any time. Padding reads do not decrement it here.
// - Writing one to bit 15 flushes receive data and status FIFOs, self-clears.
// - Offset bits 12-8 insert 0-31 bytes ahead of each received packet.
// - Upper three offset bits may change live; applied from next dword read.
package eth_host_regs_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] IRQ_SOURCE_MASK_OFFSET = 8'h5c;
  localparam logic [7:0] BYTE_ORDER_PROBE_OFFSET = 8'h64;
  localparam logic [7:0] FIFO_LEVEL_THRESHOLDS_OFFSET = 8'h68;
  localparam logic [7:0] RECEIVE_CONFIG_OFFSET = 8'h6c;

  // ----------------------------------------
  // Field layout and reset values
  // ----------------------------------------
  localparam logic [31:0] IRQ_SOURCE_MASK_RW = 32'h83bfe7df;
  localparam logic [31:0] IRQ_SOURCE_MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] BYTE_ORDER_PROBE_VALUE = 32'h8765_4321;
  localparam int TX_AVAIL_LIMIT_LSB = 24;
  localparam int TX_STAT_LIMIT_LSB = 16;
  localparam int RX_STAT_LIMIT_LSB = 0;
  localparam logic [7:0] TX_AVAIL_LIMIT_RESET = 8'h48;
  localparam logic [7:0] TX_STAT_LIMIT_RESET = 8'h00;
  localparam logic [7:0] RX_STAT_LIMIT_RESET = 8'h00;
  localparam int END_ALIGN_LSB = 30;
  localparam int DWORD_COUNTDOWN_LSB = 16;
  localparam int RX_FLUSH_BIT = 15;
  localparam int START_OFFSET_LSB = 8;
  localparam logic [1:0] END_ALIGN_RESET = 2'h0;
  localparam logic [11:0] DWORD_COUNTDOWN_RESET = 12'h000;
  localparam logic [4:0] START_OFFSET_RESET = 5'h00;

  // End alignment codes
  typedef enum logic [1:0] {
    ALIGN_4_BYTE = 2'h0,
    ALIGN_16_BYTE = 2'h1,
    ALIGN_32_BYTE = 2'h2,
    ALIGN_RESERVED = 2'h3
  } end_align_t;

  // Alignment expressed as a dword modulus minus one
  localparam logic [2:0] ALIGN_4_DWORD_MASK = 3'h0;
  localparam logic [2:0] ALIGN_16_DWORD_MASK = 3'h3;
  localparam logic [2:0] ALIGN_32_DWORD_MASK = 3'h7;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic sel;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic [7:0] tx_free_blocks;
    logic [7:0] tx_stat_used;
    logic [7:0] rx_stat_used;
  } fifo_levels_t;

  typedef struct packed {
    logic dword_read;
    logic last_dword;
  } rx_read_t;

  typedef struct packed {
    logic above;
  } level_cmp_state_t;

  typedef struct packed {
    logic [31:0] irq_source_mask;
    logic [7:0] tx_avail_limit;
    logic [7:0] tx_stat_limit;
    logic [7:0] rx_stat_limit;
    logic [1:0] end_align;
    logic [11:0] rx_dword_countdown;
    logic rx_flush;
    logic [4:0] rx_start_offset;
    logic [2:0] dword_offset_applied;
    logic [2:0] buf_pos;
    logic [2:0] pad_left;
    logic rx_pad;
    logic rx_dma_irq;
    logic host_irq;
    logic [31:0] rdata;
  } bank_state_t;

  localparam bank_state_t BANK_RESET = '{
    irq_source_mask: IRQ_SOURCE_MASK_RESET,
    tx_avail_limit: TX_AVAIL_LIMIT_RESET,
    tx_stat_limit: TX_STAT_LIMIT_RESET,
    rx_stat_limit: RX_STAT_LIMIT_RESET,
    end_align: END_ALIGN_RESET,
    rx_dword_countdown: DWORD_COUNTDOWN_RESET,
    rx_flush: 1'b0,
    rx_start_offset: START_OFFSET_RESET,
    dword_offset_applied: 3'h0,
    buf_pos: 3'h0,
    pad_left: 3'h0,
    rx_pad: 1'b0,
    rx_dma_irq: 1'b0,
    host_irq: 1'b0,
    rdata: 32'h0000_0000
  };

endpackage

// ===== core/level_above_cmp.sv
// Registered "level above limit" comparator for one FIFO threshold
`timescale 1ns/1ps
`default_nettype none

module level_above_cmp (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic [7:0] level_in,
  input wire logic [7:0] limit_in,
  output logic above_out
);

  eth_host_regs_pkg::level_cmp_state_t st;
  eth_host_regs_pkg::level_cmp_state_t next_st;

  always_comb begin
    next_st = st;
    // Strictly greater: equal level does not raise the event
    next_st.above = (level_in > limit_in);
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign above_out = st.above;

endmodule

`default_nettype wire

// ===== tb/eth_host_irq_rx_regs_properties.sv
// Port-level assertions for the host interrupt and receive config registers
`timescale 1ns/1ps
`default_nettype none
module host_regs_checker (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire eth_host_regs_pkg::host_req_t host_req_in,
  input wire logic [31:0] irq_source_status_in,
  input wire eth_host_regs_pkg::fifo_levels_t fifo_levels_in,
  input wire eth_host_regs_pkg::rx_read_t rx_read_in,
  input wire logic [31:0] host_rdata_out,
  input wire logic host_irq_out,
  input wire logic tx_space_avail_irq_out,
  input wire logic tx_stat_level_irq_out,
  input wire logic rx_stat_level_irq_out,
  input wire logic rx_dma_irq_out,
  input wire logic rx_flush_out,
  input wire logic rx_pad_out,
  input wire logic [1:0] rx_byte_offset_out,
  input wire logic [2:0] rx_dword_offset_out
);
  logic [31:0] mask;
  logic [31:0] thr;
  logic [31:0] cfg;
  logic [11:0] cnt;
  logic wr_cfg;
  logic take;
  logic probe;
  assign wr_cfg = host_req_in.sel && host_req_in.wr && host_req_in.addr == 8'h6c;
  assign probe = host_req_in.sel && host_req_in.rd && host_req_in.addr == 8'h64;
  // Pad reads are not data, so they never count down
  assign take = rx_read_in.dword_read && !rx_pad_out;
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mask <= 32'h0;
      thr <= 32'h48000000;
      cfg <= 32'h0;
      cnt <= 12'h0;
    end else begin
      if (host_req_in.sel && host_req_in.wr && host_req_in.addr == 8'h5c) begin
        mask <= host_req_in.wdata & 32'h83bfe7df;
      end
      if (host_req_in.sel && host_req_in.wr && host_req_in.addr == 8'h68) begin
        thr <= host_req_in.wdata;
      end
      if (wr_cfg) begin
        cfg <= host_req_in.wdata;
        cnt <= host_req_in.wdata[27:16];
      end else if (take && cnt != 12'h0) begin
        cnt <= cnt - 12'h1;
      end
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  a_probe_read: assert property (probe |=> host_rdata_out == 32'h87654321)
    else $error("probe read wrong");
  a_irq_gating: assert property (host_irq_out == |($past(irq_source_status_in) & $past(mask)))
    else $error("irq gating wrong");
  a_tx_space_level: assert property (tx_space_avail_irq_out ==
    ($past(fifo_levels_in.tx_free_blocks) > $past(thr[31:24]))) else $error("tx space wrong");
  a_tx_stat_level: assert property (tx_stat_level_irq_out ==
    ($past(fifo_levels_in.tx_stat_used) > $past(thr[23:16]))) else $error("tx stat wrong");
  a_rx_stat_level: assert property (rx_stat_level_irq_out ==
    ($past(fifo_levels_in.rx_stat_used) > $past(thr[7:0]))) else $error("rx stat wrong");
  a_flush_pulse: assert property (rx_flush_out == $past(wr_cfg && host_req_in.wdata[15]))
    else $error("flush pulse wrong");
  a_dma_count_end: assert property (rx_dma_irq_out == $past(take && !wr_cfg && cnt == 12'h1))
    else $error("dma pulse wrong");
  a_dword_offset: assert property (rx_read_in.dword_read |=> rx_dword_offset_out == $past(cfg[12:10]))
    else $error("dword offset wrong");
  a_no_pad_align: assert property (rx_read_in.dword_read && rx_read_in.last_dword && !rx_pad_out
    && cfg[31:30] != 2'h1 && cfg[31:30] != 2'h2 |=> !rx_pad_out) else $error("pad wrong");
  c_irq: cover property ($rose(host_irq_out));
  c_dma: cover property (rx_dma_irq_out);
  c_pad: cover property (rx_pad_out ##1 !rx_pad_out);
endmodule
bind eth_host_irq_rx_regs host_regs_checker chk (.clock_in, .rst_b_in, .host_req_in,
  .irq_source_status_in, .fifo_levels_in, .rx_read_in, .host_rdata_out, .host_irq_out,
  .tx_space_avail_irq_out, .tx_stat_level_irq_out, .rx_stat_level_irq_out, .rx_dma_irq_out,
  .rx_flush_out, .rx_pad_out, .rx_byte_offset_out, .rx_dword_offset_out);
`default_nettype wire

// ===== tb/host_cpu_model.sv
// Host processor model: register cycles and receive FIFO reads
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
  input wire logic clock_in,
  output var eth_host_regs_pkg::host_req_t host_req_out,
  output var eth_host_regs_pkg::rx_read_t rx_read_out
);
  logic [31:0] expq[$];
  initial begin
    host_req_out = '0;
    rx_read_out = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    host_req_out <= '{sel: 1'b1, wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock_in);
    host_req_out <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock_in);
    host_req_out <= '{sel: 1'b1, wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    expq.push_back(e);
    @(posedge clock_in);
    host_req_out <= '0;
  endtask
  // Pad dwords are read and thrown away like any other
  task automatic pull(input logic last);
    @(posedge clock_in);
    rx_read_out <= '{dword_read: 1'b1, last_dword: last};
    @(posedge clock_in);
    rx_read_out <= '0;
  endtask
endmodule
`default_nettype wire

// ===== tb/ethernet_host_irq_rx_cfg_regs_test.sv
// Self-checking bench for the host interrupt and receive config registers
`timescale 1ns/1ps
`default_nettype none
module ethernet_host_irq_rx_cfg_regs_test;
  logic clock_in;
  logic rst_b_in;
  logic rd_taken;
  logic [31:0] status;
  logic [31:0] x;
  logic [31:0] rdv;
  logic [31:0] seed = 32'h2234;
  eth_host_regs_pkg::fifo_levels_t lev;
  eth_host_regs_pkg::host_req_t req;
  eth_host_regs_pkg::rx_read_t rxr;
  int miscompares;
  int comparisons;
  int n;
  int al[4] = '{1, 4, 8, 1};
  logic [31:0] rdata;
  logic host_irq;
  logic tx_avail;
  logic tx_stat;
  logic rx_stat;
  logic dma;
  logic flush;
  logic pad;
  logic [1:0] byte_off;
  logic [2:0] dword_off;
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  host_cpu_model host (.clock_in(clock_in), .host_req_out(req), .rx_read_out(rxr));
  eth_host_irq_rx_regs DUT (.clock_in(clock_in), .rst_b_in(rst_b_in), .host_req_in(req),
    .irq_source_status_in(status), .fifo_levels_in(lev), .rx_read_in(rxr),
    .host_rdata_out(rdata), .host_irq_out(host_irq), .tx_space_avail_irq_out(tx_avail),
    .tx_stat_level_irq_out(tx_stat), .rx_stat_level_irq_out(rx_stat), .rx_dma_irq_out(dma),
    .rx_flush_out(flush), .rx_pad_out(pad), .rx_byte_offset_out(byte_off),
    .rx_dword_offset_out(dword_off));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Read data lands one cycle after the read edge
  always @(posedge clock_in) rd_taken <= req.sel & req.rd;
  always @(negedge clock_in) begin
    if (rd_taken === 1'b1) begin
      check("rdata", rdata, host.expq.pop_front());
    end
  end
  initial begin
    #(25 * 6000);
    miscompares++;
    finish_test();
  end
  initial begin
    rst_b_in = 1'b0;
    status = 32'h0;
    lev = '0;
    repeat (16) @(posedge clock_in);
    rst_b_in <= 1'b1;
    host.rd(8'h5c, 32'h0);
    host.rd(8'h64, 32'h87654321);
    host.rd(8'h68, 32'h48000000);
    host.rd(8'h6c, 32'h0);
    host.rd(8'h70, 32'h0);
    host.wr(8'h5c, 32'hffffffff);
    host.rd(8'h5c, 32'h83bfe7df);
    host.wr(8'h64, 32'h0);
    host.rd(8'h64, 32'h87654321);
    x = rnd();
    host.wr(8'h68, x);
    host.rd(8'h68, x & 32'hffff00ff);
    x = rnd() & 32'hffff7fff;
    host.wr(8'h6c, x);
    host.rd(8'h6c, x & 32'hcfff1f00);
    for (n = 0; n < 6; n++) begin
      x = rnd();
      host.wr(8'h5c, x);
      status <= rnd() & rnd() & rnd();
      repeat (3) @(posedge clock_in);
      @(negedge clock_in);
      check("host_irq", host_irq, |(status & x & 32'h83bfe7df));
    end
    host.wr(8'h68, 32'h30200010);
    // Equal level must stay quiet, one above must fire
    for (n = 0; n < 2; n++) begin
      @(posedge clock_in);
      lev <= {8'h30 + 8'(n), 8'h20 + 8'(n), 8'h10 + 8'(n)};
      repeat (2) @(posedge clock_in);
      @(negedge clock_in);
      check("tx_avail", tx_avail, 32'(n));
      check("tx_stat", tx_stat, 32'(n));
      check("rx_stat", rx_stat, 32'(n));
    end
    host.wr(8'h6c, 32'h8000);
    @(negedge clock_in);
    check("flush", flush, 32'h1);
    host.rd(8'h6c, 32'h0);
    host.wr(8'h6c, 32'h00050000);
    repeat (2) host.pull(1'b0);
    host.rd(8'h6c, 32'h00030000);
    host.wr(8'h6c, 32'h00020000);
    host.pull(1'b0);
    @(negedge clock_in);
    check("dma", dma, 32'h0);
    host.pull(1'b0);
    @(negedge clock_in);
    check("dma", dma, 32'h1);
    for (n = 0; n < 4; n++) begin
      host.wr(8'h6c, {n[1:0], 30'h0});
      repeat (5) host.pull(1'b0);
      host.pull(1'b1);
      rdv = 32'h0;
      @(negedge clock_in);
      while (pad === 1'b1 && rdv < 9) begin
        host.pull(1'b0);
        rdv++;
        @(negedge clock_in);
      end
      check("pad_count", rdv, 32'((al[n] - 6 % al[n]) % al[n]));
    end
    // Byte part of the offset follows each write at once; the dword part waits for a dword read
    host.wr(8'h6c, 32'h00008000);
    host.wr(8'h6c, 32'h00001700);
    host.pull(1'b0);
    @(negedge clock_in);
    check("dword_off", dword_off, 32'h5);
    check("byte_off", byte_off, 32'h3);
    host.wr(8'h6c, 32'h00000b00);
    @(negedge clock_in);
    check("dword_off", dword_off, 32'h5);
    host.pull(1'b0);
    @(negedge clock_in);
    check("dword_off", dword_off, 32'h2);
    finish_test();
  end
endmodule
`default_nettype wire
